//--- hw/impp_top.v
// Purpose: Mask, priority tree and serviced-pending register of a
//          32-source interrupt controller, with an APB register port.
// Assumes: source_pending and fast_mode_select come from logic on pclk.
// Notes:   One wait state on every APB access.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "impp_regs.vh"
module impp_top
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	input wire [31:0] source_pending,
	input wire [31:0] fast_mode_select,
	output wire normal_irq,
	output wire fast_irq
);
	reg [31:0] interrupt_mask_r;
	reg [`IMPP_ARB_W-1:0] arb_ctrl_r;
	reg [`IMPP_ARB_W-1:0] arb_ctrl_nxt;
	reg [31:0] serviced_pending_r;
	reg [31:0] serviced_pending_nxt;
	reg ack_r;
	wire [31:0] eligible;
	wire [31:0] fast_req;
	wire [35:0] arb_req;
	wire [35:0] arb_grant;
	wire [5:0] arb_any;
	wire [11:0] arb_order_nxt;
	wire [5:0] top_grant;
	wire top_any;
	wire [1:0] top_order_nxt;
	wire [31:0] winner;
	wire load;
	wire wr;
	wire rd_capture;
	wire mapped;
	genvar k;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function [4:0] impp_index;
		input [31:0] v;
		integer j;
		begin
			impp_index = 5'd0;
			for (j = 0; j < 32; j = j + 1)
			begin
				if (v[j])
				begin
					impp_index = j[4:0];
				end
			end
		end
	endfunction

	function [1:0] impp_order;
		input [`IMPP_ARB_W-1:0] ctrl;
		input integer n;
		begin
			impp_order = ctrl[`IMPP_ORD_LSB + 2 * n +: 2];
		end
	endfunction

	// ------------------------------------------------------------
	// Request gating
	// ------------------------------------------------------------
	// Source-pending is read only; mask gates forwarding alone
	assign eligible = source_pending & ~interrupt_mask_r
		& ~fast_mode_select;
	assign fast_req = source_pending & ~interrupt_mask_r & fast_mode_select;
	assign fast_irq = |fast_req;

	// ------------------------------------------------------------
	// Arbiter tree
	// ------------------------------------------------------------
	generate
		for (k = 0; k < 6; k = k + 1)
		begin : g_arb
			if (k == 0)
			begin : g_first
				assign arb_req[5:0] = {1'b0, eligible[3:0], 1'b0};
				assign winner[3:0] = arb_grant[4:1] & {4{top_grant[0]}};
			end
			else if (k == 5)
			begin : g_last
				assign arb_req[35:30] =
					{1'b0, eligible[31:28], 1'b0};
				assign winner[31:28] = arb_grant[34:31] & {4{top_grant[5]}};
			end
			else
			begin : g_mid
				assign arb_req[6*k +: 6] = eligible[6*k-2 +: 6];
				assign winner[6*k-2 +: 6] =
					arb_grant[6*k +: 6] & {6{top_grant[k]}};
			end
			impp_arbiter u_arb
			(
				.req(arb_req[6*k +: 6]),
				.order(impp_order(arb_ctrl_r, k)),
				.grant(arb_grant[6*k +: 6]),
				.any(arb_any[k]),
				.order_nxt(arb_order_nxt[2*k +: 2])
			);
		end
	endgenerate

	impp_arbiter u_arb_top
	(
		.req(arb_any),
		.order(impp_order(arb_ctrl_r, 6)),
		.grant(top_grant),
		.any(top_any),
		.order_nxt(top_order_nxt)
	);

	// New winner only enters when nothing is being serviced
	assign load = top_any && (serviced_pending_r == 32'h0000_0000);

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	reg sel_mask;
	reg sel_arb;
	reg sel_pend;
	reg sel_index;
	wire wr_mask;
	wire wr_arb;
	wire wr_pend;

	function impp_hit;
		input [31:0] addr;
		input [31:0] target;
		begin
			impp_hit = (addr == target);
		end
	endfunction

	// Exact word match only; anything else answers with an error
	always @*
	begin
		sel_mask = 1'b0;
		sel_arb = 1'b0;
		sel_pend = 1'b0;
		sel_index = 1'b0;
		if (impp_hit(paddr, `IMPP_ADDR_MASK))
		begin
			sel_mask = 1'b1;
		end
		else if (impp_hit(paddr, `IMPP_ADDR_ARB))
		begin
			sel_arb = 1'b1;
		end
		else if (impp_hit(paddr, `IMPP_ADDR_PEND))
		begin
			sel_pend = 1'b1;
		end
		else if (impp_hit(paddr, `IMPP_ADDR_INDEX))
		begin
			sel_index = 1'b1;
		end
	end

	// One wait state: ready in the second access cycle
	assign pready = psel & penable & ack_r;
	assign wr = pready & pwrite;
	assign rd_capture = psel & penable & ~ack_r & ~pwrite;
	assign mapped = sel_mask | sel_arb | sel_pend | sel_index;
	assign pslverr = pready & ~mapped;
	// Index is read only, so it has no write strobe
	assign wr_mask = wr & sel_mask;
	assign wr_arb = wr & sel_arb;
	assign wr_pend = wr & sel_pend;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ack_r <= 1'b0;
		end
		else
		begin
			ack_r <= psel & penable & ~ack_r;
		end
	end

	// ------------------------------------------------------------
	// Arbitration control: rotation, software write wins
	// ------------------------------------------------------------
	integer a;
	always @*
	begin
		arb_ctrl_nxt = arb_ctrl_r;
		if (load)
		begin
			for (a = 0; a < 6; a = a + 1)
			begin
				if (top_grant[a] && arb_ctrl_r[`IMPP_ROT_LSB + a])
				begin
					arb_ctrl_nxt[`IMPP_ORD_LSB + 2 * a +: 2] =
						arb_order_nxt[2*a +: 2];
				end
			end
			if (arb_ctrl_r[`IMPP_ROT_LSB + 6])
			begin
				arb_ctrl_nxt[`IMPP_ORD_LSB + 12 +: 2] =
					top_order_nxt;
			end
		end
		if (wr_arb)
		begin
			arb_ctrl_nxt = pwdata[`IMPP_ARB_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Serviced-pending: set wins over clear
	// ------------------------------------------------------------
	always @*
	begin
		serviced_pending_nxt = serviced_pending_r;
		// Ones clear, zeros leave the bit alone
		if (wr_pend)
		begin
			serviced_pending_nxt = serviced_pending_r & ~pwdata;
		end
		if (load)
		begin
			serviced_pending_nxt = serviced_pending_nxt | winner;
		end
	end

	// ------------------------------------------------------------
	// Mask register
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			interrupt_mask_r <= `IMPP_RST_MASK;
		end
		else if (wr_mask)
		begin
			interrupt_mask_r <= pwdata;
		end
	end

	// ------------------------------------------------------------
	// Arbitration control register
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			arb_ctrl_r <= `IMPP_RST_ARB;
		end
		else
		begin
			arb_ctrl_r <= arb_ctrl_nxt;
		end
	end

	// ------------------------------------------------------------
	// Serviced-pending register
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			serviced_pending_r <= `IMPP_RST_PEND;
		end
		else
		begin
			serviced_pending_r <= serviced_pending_nxt;
		end
	end

	// Set bit drives the processor request
	assign normal_irq = |serviced_pending_r;

	// ------------------------------------------------------------
	// Index register
	// ------------------------------------------------------------
	// Follows pending on the same edge, so it clears with it
	reg [4:0] pending_index_r;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pending_index_r <= 5'h0;
		end
		else
		begin
			pending_index_r <= impp_index(serviced_pending_nxt);
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	reg [31:0] rd_mux;
	always @*
	begin
		rd_mux = 32'h0000_0000;
		if (sel_mask)
		begin
			rd_mux = interrupt_mask_r;
		end
		else if (sel_arb)
		begin
			rd_mux = {11'h0, arb_ctrl_r};
		end
		else if (sel_pend)
		begin
			rd_mux = serviced_pending_r;
		end
		else if (sel_index)
		begin
			rd_mux = {27'h0, pending_index_r};
		end
	end

	// Captured in the first access cycle, stands until next read
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
		end
		else if (rd_capture)
		begin
			prdata <= rd_mux;
		end
	end
endmodule

//--- inc/impp_regs.vh
// Purpose: Register map and field constants of the interrupt mask,
//          priority and serviced-pending stage.
// Assumes: APB slave, 32-bit data, one aligned word per register.
// Notes:   Full byte addresses are decoded.
// Behaviour
// - One mask bit per source; 1 blocks service, 0 lets request arbitrate.
// - Masking never stops source-pending recording; only forwarding is blocked.
// - Mask register resets to all ones, every source masked.
// - Rotate-enable bits 0..6, one per arbiter; reset value 0x7F.
// - Arbiters 0 and 5 rank requests 1..4 by a rotating start code.
// - Arbiters 1-4 and 6: request 0 highest, 5 lowest, middle four rotate.
// - Order fields at 8:7, 10:9, 12:11, 14:13, 16:15, 18:17 and 20:19; reset 00.
// - Serviced-pending holds at most one bit, the winner; drives normal irq.
// - Writing serviced-pending clears bits written 1; reset all zeros.
// - Fast-mode sources never set a serviced-pending bit.
// - Source-pending is set by sources regardless of mask or priority.
// - Mode bit 1 routes a source to fast handling; only one such source. The code accepts any number of them and ORs them onto fast_irq.
// - Index register reports winner position, clears when pending clears.
`ifndef IMPP_REGS_VH
`define IMPP_REGS_VH

`define IMPP_ADDR_MASK 32'h4a00_0008
`define IMPP_ADDR_ARB 32'h4a00_000c
`define IMPP_ADDR_PEND 32'h4a00_0010
`define IMPP_ADDR_INDEX 32'h4a00_0014

`define IMPP_RST_MASK 32'hffff_ffff
`define IMPP_RST_ARB 21'h0_007f
`define IMPP_RST_PEND 32'h0000_0000

`define IMPP_ARB_W 21
`define IMPP_ROT_LSB 0
`define IMPP_ORD_LSB 7
`define IMPP_NUM_ARB 7

`endif

//--- hw/impp_arbiter.v
// Purpose: One six-input arbiter with a rotating middle group.
// Assumes: Inputs 0 and 5 tied low where the arbiter has four inputs.
// Notes:   Purely combinational; order update is applied by the parent.
`timescale 1ns/1ps
module impp_arbiter
(
	input wire [5:0] req,
	input wire [1:0] order,
	output reg [5:0] grant,
	output wire any,
	output reg [1:0] order_nxt
);
	reg [2:0] idx;
	integer i;

	assign any = |req;

	// ------------------------------------------------------------
	// Fixed ends, rotating middle
	// ------------------------------------------------------------
	always @*
	begin
		grant = 6'h00;
		idx = 3'd0;
		order_nxt = order;
		if (req[0])
		begin
			grant[0] = 1'b1;
		end
		else
		begin
			for (i = 3; i >= 0; i = i - 1)
			begin
				idx = {1'b0, order + i[1:0]} + 3'd1;
				if (req[idx])
				begin
					grant = 6'h00;
					grant[idx] = 1'b1;
					order_nxt = idx[1:0];
				end
			end
			if (grant == 6'h00 && req[5])
			begin
				grant[5] = 1'b1;
			end
		end
	end
endmodule

//--- tb/impp_src_model.sv
// Purpose: Source-pending stage in front of impp_top.
// Assumes: Set and clear pulses come from the bench.
// Notes:   Clear wins over set in the same cycle.
`timescale 1ns/1ps
module impp_src_model
(
	input wire pclk,
	input wire presetn,
	input wire [31:0] set_req,
	input wire [31:0] clr_req,
	output reg [31:0] src_pnd_r
);
always @(posedge pclk or negedge presetn)
	if (!presetn)
		src_pnd_r <= 32'h0000_0000;
	else
		src_pnd_r <= (src_pnd_r | set_req) & ~clr_req;
endmodule

//--- tb/impp_chk.sv
// Purpose: Port checks of impp_top.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound into every impp_top.
`timescale 1ns/1ps
module impp_chk
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire [31:0] source_pending,
	input wire [31:0] fast_mode_select,
	input wire normal_irq,
	input wire fast_irq
);
// ----
// Checks
// ----
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
wire acc = psel & penable;
wait_state_a: assert property ($rose(acc) |-> !pready ##1 pready)
	else $error("no single wait state");
err_ack_a: assert property (pslverr |-> pready)
	else $error("error without ready");
ready_acc_a: assert property (pready |-> acc)
	else $error("ready outside access");
rd_hold_a: assert property ($changed(prdata) |-> $past(acc && !pwrite))
	else $error("read data moved without read");
rst_idle_a: assert property (!$past(presetn) |-> !normal_irq)
	else $error("irq right after reset");
irq_cause_a: assert property ($rose(normal_irq) |->
	$past(|(source_pending & ~fast_mode_select)))
	else $error("irq without normal source");
irq_clear_a: assert property ($fell(normal_irq) |->
	$past(acc && pwrite && pready))
	else $error("irq fell without write");
fast_src_a: assert property (fast_irq |->
	|(source_pending & fast_mode_select))
	else $error("fast irq without fast source");
irq_c: cover property ($rose(normal_irq));
fast_c: cover property ($rose(fast_irq));
err_c: cover property (pslverr);
endmodule
bind impp_top impp_chk impp_chk_inst (.*);

//--- tb/tb_top.sv
// Purpose: Self-checking bench of impp_top.
// Assumes: Source stage model on the far side.
// Notes:   Table rows hold plain register access.
`timescale 1ns/1ps
`include "impp_regs.vh"
module tb_top;
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
logic [31:0] paddr = 0, pwdata = 0, fast_mode_select = 0, rd;
logic [31:0] set_req = 0, clr_req = 0;
wire pready, pslverr, normal_irq, fast_irq;
wire [31:0] prdata, source_pending;
int bad_count = 0, tests_run = 0, k, c, b;
logic [31:0] rows [5][4] = '{
	'{`IMPP_ADDR_MASK, 32'h1234_5678, 32'h1234_5678, 0},
	'{`IMPP_ADDR_ARB, 32'hffff_ffff, 32'h001f_ffff, 0},
	'{`IMPP_ADDR_PEND, 32'hffff_ffff, 0, 0},
	'{`IMPP_ADDR_INDEX, 32'h0000_001f, 0, 0},
	'{32'h4a00_0018, 32'h0000_0001, 0, 1}};
always #2.5 pclk = ~pclk;
impp_top impp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .prdata(prdata), .pslverr(pslverr),
	.source_pending(source_pending), .fast_mode_select(fast_mode_select),
	.normal_irq(normal_irq), .fast_irq(fast_irq));
impp_src_model impp_src_model_inst (.pclk(pclk), .presetn(presetn),
	.set_req(set_req), .clr_req(clr_req), .src_pnd_r(source_pending));
// ----
// Tasks
// ----
task chk(input logic [31:0] g, e);
	tests_run++;
	if (g !== e)
	begin
		bad_count++;
		$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
	end
endtask
task apb(input logic w, input logic [31:0] a, d);
	int n;
	@(posedge pclk);
	psel <= 1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1;
	n = 0;
	do
	begin
		@(posedge pclk);
		n++;
	end
	while (pready !== 1 && n < 16);
	rd = prdata;
	er = pslverr;
	psel <= 0;
	penable <= 0;
	if (n >= 16)
		chk(0, 1);
endtask
task src(input logic [31:0] s, cl);
	@(posedge pclk);
	set_req <= s;
	clr_req <= cl;
	@(posedge pclk);
	set_req <= 0;
	clr_req <= 0;
endtask
task wirq;
	@(negedge pclk);
	repeat (8)
		if (normal_irq !== 1)
			@(negedge pclk);
	chk(normal_irq, 1);
endtask
task win(input logic [31:0] ctl, rq, ex);
	apb(1, `IMPP_ADDR_ARB, ctl);
	src(rq, 0);
	wirq;
	apb(0, `IMPP_ADDR_PEND, 0);
	chk(rd, ex);
	src(0, rq);
	apb(1, `IMPP_ADDR_PEND, rd);
endtask
task done(input string s);
	$display("test %s done", s);
endtask
task stop_test;
	$display("checks %0d mismatches %0d", tests_run, bad_count);
	if (bad_count == 0 && tests_run > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask
initial
begin
	#100000;
	bad_count++;
	stop_test;
end
// ----
// Main
// ----
initial
begin
	repeat (16) @(posedge pclk);
	presetn <= 1;
	for (k = 0; k < 5; k++)
	begin
		apb(1, rows[k][0], rows[k][1]);
		chk(er, rows[k][3]);
		apb(0, rows[k][0], 0);
		chk(rd, rows[k][2]);
		chk(er, rows[k][3]);
	end
	done("rows");
	presetn <= 0;
	repeat (16) @(posedge pclk);
	presetn <= 1;
	apb(0, `IMPP_ADDR_MASK, 0);
	chk(rd, 32'hffff_ffff);
	apb(0, `IMPP_ADDR_ARB, 0);
	chk(rd, 32'h0000_007f);
	apb(0, `IMPP_ADDR_PEND, 0);
	chk(rd, 0);
	done("reset");
	src(32'h0000_0020, 0);
	repeat (4) @(negedge pclk);
	chk(normal_irq, 0);
	chk(source_pending, 32'h0000_0020);
	apb(1, `IMPP_ADDR_MASK, 32'hffff_ffdf);
	wirq;
	apb(1, `IMPP_ADDR_PEND, 32'hffff_ffdf);
	apb(0, `IMPP_ADDR_PEND, 0);
	chk(rd, 32'h0000_0020);
	apb(0, `IMPP_ADDR_INDEX, 0);
	chk(rd, 5);
	src(0, 32'h0000_0020);
	apb(1, `IMPP_ADDR_PEND, 32'h0000_0020);
	@(negedge pclk);
	chk(normal_irq, 0);
	done("mask");
	apb(1, `IMPP_ADDR_MASK, 0);
	for (k = 0; k < 6; k++)
		for (c = 0; c < 4; c++)
		begin
			b = k == 0 ? 0 : k == 5 ? 28 : 6 * k - 1;
			win(c << (7 + 2 * k), 32'hf << b, 1 << (b + c));
		end
	win(3 << 9, 32'h0000_0110, 32'h0000_0010);
	win(1 << 19, 32'h0000_0820, 32'h0000_0800);
	done("order");
	apb(1, `IMPP_ADDR_ARB, 32'h0000_007f);
	src(32'h0000_0006, 0);
	wirq;
	apb(0, `IMPP_ADDR_ARB, 0);
	chk(rd, 32'h0000_017f);
	apb(1, `IMPP_ADDR_PEND, 32'h0000_0002);
	wirq;
	apb(0, `IMPP_ADDR_PEND, 0);
	chk(rd, 32'h0000_0004);
	src(0, 32'h0000_0006);
	apb(1, `IMPP_ADDR_PEND, 32'h0000_0004);
	done("rotate");
	@(posedge pclk);
	fast_mode_select <= 32'h0000_0008;
	src(32'h0000_0008, 0);
	repeat (3) @(negedge pclk);
	chk(normal_irq, 0);
	chk(fast_irq, 1);
	apb(0, `IMPP_ADDR_PEND, 0);
	chk(rd, 0);
	done("fast");
	stop_test;
end
endmodule
